// ---- hw/spm_port.sv ----
/*
  Byte-wide full-duplex serial peripheral port, master or slave, with APB registers.
  Assumes pins are synchronous to sys_clk and the far side keeps the bus protocol.
*/
// The APB interface to the registers and the address map were left to the implementer.
//Contract
//- Eight-bit shift register sends MSB first, new bit enters at LSB.
//- Data driven on the programmed clock edge, captured on the opposite edge.
//- Master starts by issuing clock; both ends share clock idle polarity.
//- After eight clocks master and slave have swapped register contents.
//- Unselected slave ignores clock and data and drives nothing.
//- Status low six bits read-only, top two writable; control one fully writable.
//- Baud value register reloads the master rate generator in one option.
//- Completed byte is copied to buffer, sets buffer-full and interrupt flags.
//- Transmit unbuffered: data write loads buffer and shift register together.
//- Control fields choose role, polarity, sample phase, edge, rate, select mode.
//- Enable bit activates the port and its pins; reconfigure while disabled.
//- Master drives the serial clock pin; slave takes it as input.
//- Receive double-buffered so the next byte may start before reading.
//- Data write during shifting is dropped, sets collision; writes fail until cleared.
//- Reading the data buffer clears buffer-full.
//- Master transfer starts as soon as software writes the data buffer.
//- Master rate is clock/4, /16, /64, timer/2 or baud-derived.
//- Slave select mode: select high floats output and zeroes the bit counter.
//- Clock polarity sets the idle level of the serial clock.
`timescale 1ns/1ns
module spm_port (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerTick,
  input wire logic serialClockPinIn,
  output logic serialClockPinOut,
  output logic serialClockPinOe,
  output logic serialOutPin,
  output logic serialOutPinOe,
  input wire logic serialInPin,
  input wire logic slaveSelectPinN,
  output logic portInterruptFlag
);

  spm_pkg::spm_ctrl1_t ctrl_ff;
  spm_pkg::spm_cfg_t cfg_ff;
  spm_pkg::spm_state_t state_ff;
  logic [7:0] baud_ff;
  logic [7:0] shift_ff;
  logic [7:0] dataBuf_ff;
  logic [31:0] prdata_ff;
  logic [4:0] edgeCnt_ff;
  logic bf_ff;
  logic irq_ff;
  logic rxBit_ff;
  logic sckLvl_ff;
  logic sckPrev_ff;

  logic access, wrAcc, rdAcc, wrData, rdData, wrFlagClr;
  logic isMaster, selMode, deselected, busy, load, start, collide;
  logic halfTick, mLead, mTrail, sLead, sTrail, lead, trail;
  logic sampleEdge, shiftEdge, lastEdge, doShift, inBit, slvActive;
  logic [7:0] shiftNext;

  function automatic logic masterMode(input logic [3:0] m);
    masterMode = (m != spm_pkg::MODE_SLV_SEL) && (m != spm_pkg::MODE_SLV_NOSEL);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == spm_pkg::OFF_CTRL1) || (a == spm_pkg::OFF_STAT) ||
             (a == spm_pkg::OFF_DATA) || (a == spm_pkg::OFF_BAUD) ||
             (a == spm_pkg::OFF_FLAG);
  endfunction

  // Bus decode: zero wait states, error on unmapped address
  assign access = psel && penable;
  assign wrAcc = access && pwrite && mapped(paddr);
  assign rdAcc = access && !pwrite;
  assign wrData = wrAcc && (paddr == spm_pkg::OFF_DATA);
  assign rdData = rdAcc && (paddr == spm_pkg::OFF_DATA);
  assign wrFlagClr = wrAcc && (paddr == spm_pkg::OFF_FLAG) && pwdata[spm_pkg::FLAG_BIT];
  assign pready = access;
  assign pslverr = access && !mapped(paddr);
  assign prdata = prdata_ff;

  assign isMaster = masterMode(ctrl_ff.mode);
  assign selMode = (ctrl_ff.mode == spm_pkg::MODE_SLV_SEL);
  assign deselected = selMode && slaveSelectPinN;
  assign slvActive = ctrl_ff.en && !isMaster && !deselected;
  assign busy = isMaster ? (state_ff == spm_pkg::SPM_SHIFT) : (edgeCnt_ff != spm_pkg::EDGE_FIRST);

  // Write while shifting, or before collision is cleared, is dropped
  assign collide = wrData && busy;
  assign load = wrData && !busy && !ctrl_ff.write_collision_flag;
  assign start = load && ctrl_ff.en && isMaster;

  spm_rate_gen u_rate (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(start),
    .mode(ctrl_ff.mode),
    .baud(baud_ff),
    .timerTick(timerTick),
    .halfTick(halfTick)
  );

  // Master edges alternate leading, trailing; slave edges from the pin
  assign mLead = (state_ff == spm_pkg::SPM_SHIFT) && halfTick && !edgeCnt_ff[0];
  assign mTrail = (state_ff == spm_pkg::SPM_SHIFT) && halfTick && edgeCnt_ff[0];
  assign sLead = slvActive && (sckPrev_ff == ctrl_ff.clock_idle_polarity) && (serialClockPinIn != ctrl_ff.clock_idle_polarity);
  assign sTrail = slvActive && (sckPrev_ff != ctrl_ff.clock_idle_polarity) && (serialClockPinIn == ctrl_ff.clock_idle_polarity);
  assign lead = isMaster ? mLead : sLead;
  assign trail = isMaster ? mTrail : sTrail;

  // Clock edge select: output changes on one edge, input sampled on the other
  assign sampleEdge = cfg_ff.cke ? lead : trail;
  assign shiftEdge = cfg_ff.cke ? trail : lead;
  assign lastEdge = trail && (edgeCnt_ff == spm_pkg::EDGE_LAST);
  // Output-on-leading: first leading edge only presents the MSB; last bit shifts at the end
  assign doShift = (shiftEdge && !(!cfg_ff.cke && edgeCnt_ff == spm_pkg::EDGE_FIRST)) ||
                   (lastEdge && !cfg_ff.cke);
  // Master late sampling takes the pin at the shifting edge instead of the held sample
  assign inBit = ((isMaster && cfg_ff.input_sample_phase) || (lastEdge && !cfg_ff.cke)) ? serialInPin : rxBit_ff;
  assign shiftNext = {shift_ff[spm_pkg::BYTE_MSB - 1:0], inBit};

  // Pins
  assign serialClockPinOut = sckLvl_ff;
  assign serialClockPinOe = ctrl_ff.en && isMaster;
  assign serialOutPin = shift_ff[spm_pkg::BYTE_MSB];
  assign serialOutPinOe = ctrl_ff.en && (isMaster || !deselected);
  assign portInterruptFlag = irq_ff;

  // Control register one: all bits writable, collision set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_ff <= spm_pkg::CTRL1_RST;
    end else begin
      if (wrAcc && paddr == spm_pkg::OFF_CTRL1) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (collide) begin
        ctrl_ff.write_collision_flag <= 1'b1;
      end
    end
  end

  // Status upper two bits writable, lower six read-only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_ff <= spm_pkg::CFG_RST;
    end else if (wrAcc && paddr == spm_pkg::OFF_STAT) begin
      cfg_ff <= pwdata[spm_pkg::BYTE_MSB:spm_pkg::CFG_LSB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      baud_ff <= spm_pkg::BAUD_RST;
    end else if (wrAcc && paddr == spm_pkg::OFF_BAUD) begin
      baud_ff <= pwdata[7:0];
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata_ff <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        spm_pkg::OFF_CTRL1: prdata_ff <= {24'h000000, ctrl_ff};
        spm_pkg::OFF_STAT: prdata_ff <= {24'h000000, cfg_ff, 5'h00, bf_ff};
        spm_pkg::OFF_DATA: prdata_ff <= {24'h000000, dataBuf_ff};
        spm_pkg::OFF_BAUD: prdata_ff <= {24'h000000, baud_ff};
        spm_pkg::OFF_FLAG: prdata_ff <= {31'h00000000, irq_ff};
        default: prdata_ff <= '0;
      endcase
    end
  end

  // Master sequencing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= spm_pkg::SPM_IDLE;
    end else begin
      case (state_ff)
        spm_pkg::SPM_IDLE: begin
          if (start) begin
            state_ff <= spm_pkg::SPM_SHIFT;
          end
        end
        spm_pkg::SPM_SHIFT: begin
          if (lastEdge || !ctrl_ff.en || !isMaster) begin
            state_ff <= spm_pkg::SPM_IDLE;
          end
        end
        default: state_ff <= spm_pkg::SPM_IDLE;
      endcase
    end
  end

  // Master clock rests at the idle level and toggles each half period
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sckLvl_ff <= 1'b0;
    end else if (state_ff != spm_pkg::SPM_SHIFT) begin
      sckLvl_ff <= ctrl_ff.clock_idle_polarity;
    end else if (halfTick) begin
      sckLvl_ff <= !sckLvl_ff;
    end
  end

  // Pin history for slave edge detection, tracked even while disabled
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sckPrev_ff <= 1'b0;
    end else begin
      sckPrev_ff <= serialClockPinIn;
    end
  end

  // Edge counter, cleared by disable or by a raised select
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !ctrl_ff.en || deselected || start) begin
      edgeCnt_ff <= spm_pkg::EDGE_FIRST;
    end else if (lastEdge) begin
      edgeCnt_ff <= spm_pkg::EDGE_FIRST;
    end else if (lead || trail) begin
      edgeCnt_ff <= edgeCnt_ff + spm_pkg::EDGE_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxBit_ff <= 1'b0;
    end else if (sampleEdge) begin
      rxBit_ff <= serialInPin;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shift_ff <= spm_pkg::BYTE_ZERO;
    end else if (load) begin
      shift_ff <= pwdata[7:0];
    end else if (doShift) begin
      shift_ff <= shiftNext;
    end
  end

  // Buffer: written by software or by a completed byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dataBuf_ff <= spm_pkg::BYTE_ZERO;
    end else if (load) begin
      dataBuf_ff <= pwdata[7:0];
    end else if (lastEdge) begin
      dataBuf_ff <= shiftNext;
    end
  end

  // Buffer-full: completion wins over a clearing read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bf_ff <= 1'b0;
    end else if (lastEdge) begin
      bf_ff <= 1'b1;
    end else if (rdData) begin
      bf_ff <= 1'b0;
    end
  end

  // Interrupt flag: write one to clear, completion wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else if (lastEdge) begin
      irq_ff <= 1'b1;
    end else if (wrFlagClr) begin
      irq_ff <= 1'b0;
    end
  end

  property p_start;
    @(posedge sys_clk) disable iff (sys_rst)
    start |=> (state_ff == spm_pkg::SPM_SHIFT) && (shift_ff == $past(pwdata[7:0]));
  endproperty
  a_start: assert property (p_start) else $error("write did not start master transfer");

  property p_bf;
    @(posedge sys_clk) disable iff (sys_rst)
    lastEdge |=> bf_ff && irq_ff && (dataBuf_ff == $past(shiftNext));
  endproperty
  a_bf: assert property (p_bf) else $error("completed byte not latched with flags");

  property p_bfclr;
    @(posedge sys_clk) disable iff (sys_rst)
    (rdData && !lastEdge) |=> !bf_ff;
  endproperty
  a_bfclr: assert property (p_bfclr) else $error("buffer read left buffer-full set");

  property p_write_collision_flag;
    @(posedge sys_clk) disable iff (sys_rst)
    collide |=> ctrl_ff.write_collision_flag && !$past(load);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_irqhold;
    @(posedge sys_clk) disable iff (sys_rst)
    (irq_ff && !wrFlagClr) |=> irq_ff;
  endproperty
  a_irqhold: assert property (p_irqhold) else $error("interrupt flag dropped");

  property p_desel;
    @(posedge sys_clk) disable iff (sys_rst)
    (ctrl_ff.en && !isMaster && deselected) |->
      !serialOutPinOe ##1 (edgeCnt_ff == spm_pkg::EDGE_FIRST);
  endproperty
  a_desel: assert property (p_desel) else $error("deselected slave still active");

  property p_idle;
    @(posedge sys_clk) disable iff (sys_rst)
    (state_ff == spm_pkg::SPM_IDLE && $past(state_ff == spm_pkg::SPM_IDLE) &&
     $stable(ctrl_ff.clock_idle_polarity)) |-> (serialClockPinOut == ctrl_ff.clock_idle_polarity);
  endproperty
  a_idle: assert property (p_idle) else $error("serial clock not at idle level");

  property p_sckoe;
    @(posedge sys_clk) disable iff (sys_rst)
    (ctrl_ff.en && isMaster) |-> serialClockPinOe ##1
      (!$past(lead || trail) || (serialClockPinOut != $past(serialClockPinOut)));
  endproperty
  a_sckoe: assert property (p_sckoe) else $error("master not driving clock");

  property p_msb;
    @(posedge sys_clk) disable iff (sys_rst)
    doShift |=> (serialOutPin == $past(shift_ff[spm_pkg::BYTE_MSB - 1]));
  endproperty
  a_msb: assert property (p_msb) else $error("shift order wrong");

  c_master: cover property (@(posedge sys_clk) disable iff (sys_rst) lastEdge && isMaster);
  c_slave: cover property (@(posedge sys_clk) disable iff (sys_rst) lastEdge && !isMaster);
  c_write_collision_flag: cover property (@(posedge sys_clk) disable iff (sys_rst) collide);

endmodule

// ---- hw/spm_pkg.sv ----
/*
  Constants, register map and field layouts of the byte-wide serial peripheral port.
  Assumes a 32-bit APB register bus with byte addresses and the 100 MHz system clock.
*/
package spm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_BAUD = 8'h0C;
  localparam logic [7:0] OFF_FLAG = 8'h10;

  // Mode codes of serial_port_control_one[3:0]
  localparam logic [3:0] MODE_DIV4 = 4'h0;
  localparam logic [3:0] MODE_DIV16 = 4'h1;
  localparam logic [3:0] MODE_DIV64 = 4'h2;
  localparam logic [3:0] MODE_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLV_SEL = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSEL = 4'h5;
  localparam logic [3:0] MODE_BAUD = 4'hA;

  // Half serial clock periods in system clocks
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;
  localparam logic [9:0] HALF_ONE = 10'h001;

  // Sixteen clock edges make one byte; the count runs 0 to 15
  localparam logic [4:0] EDGE_FIRST = 5'h00;
  localparam logic [4:0] EDGE_LAST = 5'h0F;
  localparam logic [4:0] EDGE_STEP = 5'h01;

  // Field positions
  localparam int unsigned BF_BIT = 0;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned CFG_LSB = 6;
  localparam int unsigned BYTE_MSB = 7;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic write_collision_flag;
    logic ovf;
    logic en;
    logic clock_idle_polarity;
    logic [3:0] mode;
  } spm_ctrl1_t;

  typedef struct packed {
    logic input_sample_phase;
    logic cke;
  } spm_cfg_t;

  typedef enum logic {
    SPM_IDLE,
    SPM_SHIFT
  } spm_state_t;

endpackage

// ---- hw/spm_rate_gen.sv ----
/*
  Master serial clock pacing: one-cycle pulse at every half period of the serial clock.
  Assumes restart is pulsed when a transfer starts and the mode is steady during it.
*/
`timescale 1ns/1ns
module spm_rate_gen (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic [3:0] mode,
  input wire logic [7:0] baud,
  input wire logic timerTick,
  output logic halfTick
);

  logic [9:0] cnt_ff;
  logic [9:0] halfLen;
  logic wrap;

  // Baud option: period 4*(baud+1) system clocks, half of it is 2*(baud+1)
  always_comb begin
    case (mode)
      spm_pkg::MODE_DIV16: halfLen = spm_pkg::HALF_DIV16;
      spm_pkg::MODE_DIV64: halfLen = spm_pkg::HALF_DIV64;
      spm_pkg::MODE_BAUD: halfLen = 10'(({2'h0, baud} + spm_pkg::HALF_ONE) << 1);
      default: halfLen = spm_pkg::HALF_DIV4;
    endcase
  end

  assign wrap = (cnt_ff == halfLen - spm_pkg::HALF_ONE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || restart || wrap) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + spm_pkg::HALF_ONE;
    end
  end

  // Timer option toggles the clock on each timer pulse, giving timer rate / 2
  assign halfTick = !restart && ((mode == spm_pkg::MODE_TIMER) ? timerTick : wrap);

endmodule

// ---- sim/spm_peer.sv ----
/*
  Far-side serial peer: a slave on the port's clock, or a master with its own clock and select.
  Assumes all pins are sampled on sys_clk and the bench resolves the shared wires.
*/
`timescale 1ns/1ns
module spm_peer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic asMaster,
  input wire logic clock_idle_polarity,
  input wire logic cke,
  input wire logic [7:0] txByte,
  input wire logic load,
  input wire logic go,
  input wire logic [4:0] nEdges,
  input wire logic [5:0] halfP,
  input wire logic sckIn,
  input wire logic selInN,
  input wire logic dataIn,
  output logic sckOut,
  output logic selOutN,
  output logic dataOut,
  output logic [7:0] rxByte,
  output logic busy
);
  logic [7:0] sr;
  logic outBit, sckPrev, dataPrev, sck, sel, lead, trail;
  logic [5:0] cnt;
  logic [4:0] edgeCnt;
  assign sck = asMaster ? sckOut : sckIn;
  assign sel = asMaster ? ~selOutN : ~selInN;
  assign lead = sel && (sckPrev == clock_idle_polarity) && (sck != clock_idle_polarity);
  assign trail = sel && (sckPrev != clock_idle_polarity) && (sck == clock_idle_polarity);
  // Released line shows the inverse of the last bit
  assign dataOut = sel ? outBit : ~outBit;
  always @(posedge sys_clk) sckPrev <= sck;
  // Edges are seen one cycle late, so take the data level that stood at the edge
  always @(posedge sys_clk) dataPrev <= dataIn;
  // Drive on one edge, capture on the other
  always @(posedge sys_clk) begin
    if (load) begin
      sr <= txByte;
      outBit <= txByte[7];
    end else if ((lead && !cke) || (trail && cke)) begin
      outBit <= cke ? sr[6] : sr[7];
      sr <= {sr[6:0], 1'h0};
    end
    if ((lead && cke) || (trail && !cke))
      rxByte <= {rxByte[6:0], dataPrev};
  end
  // Own frame: select, clock edges, then stop the clock before release
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sckOut <= 1'h0;
      selOutN <= 1'h1;
      busy <= 1'h0;
    end else if (go) begin
      busy <= 1'h1;
      selOutN <= 1'h0;
      cnt <= 6'h00;
      edgeCnt <= 5'h00;
    end else if (busy) begin
      cnt <= (cnt == halfP) ? 6'h00 : cnt + 6'h01;
      if (cnt == halfP && edgeCnt == nEdges) begin
        selOutN <= 1'h1;
        busy <= 1'h0;
      end else if (cnt == halfP) begin
        sckOut <= ~sckOut;
        edgeCnt <= edgeCnt + 5'h01;
      end
    end else
      sckOut <= clock_idle_polarity;
  end
endmodule

// ---- sim/tb_top.sv ----
/*
  Testbench of the serial port: APB tasks, register checks, master and slave runs.
  Assumes a zero-wait APB slave and a pull-up on the port's data output line.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
  end \
end
module tb_top;
  logic sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, pTx = 8'h00, pRx;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sckOut, sckOe, sdo, sdoOe, flag, sckWire, sdoWire, selWire;
  logic pMaster = 1'h0, pCkp = 1'h0, pCke = 1'h0, pLoad = 1'h0, pGo = 1'h0, tbSelN = 1'h1;
  logic blockSel = 1'h0, timerTick = 1'h0, sckPrev, pSck, pSelN, pData, pBusy;
  logic [4:0] pEdges = 5'h10, polTab = 5'h16, phTab = 5'h15;
  logic [1:0] tickCnt = 2'h0;
  logic smpBit = 1'h0;
  logic [3:0] mdTab [5] = '{spm_pkg::MODE_DIV4, spm_pkg::MODE_DIV16, spm_pkg::MODE_DIV64,
    spm_pkg::MODE_TIMER, spm_pkg::MODE_BAUD};
  int halfTab [5] = '{int'(spm_pkg::HALF_DIV4), int'(spm_pkg::HALF_DIV16),
    int'(spm_pkg::HALF_DIV64), 3, 2 * (2 + 1)};
  int n_fail = 0, compares = 0, edges = 0, mark = 0, cyc = 0, firstCyc = 0, lastCyc = 0;
  assign sckWire = sckOe ? sckOut : pSck;
  assign sdoWire = sdoOe ? sdo : 1'h1;
  assign selWire = pMaster ? (pSelN | blockSel) : 1'h1;
  spm_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerTick(timerTick), .serialClockPinIn(sckWire),
    .serialClockPinOut(sckOut), .serialClockPinOe(sckOe), .serialOutPin(sdo),
    .serialOutPinOe(sdoOe), .serialInPin(pData), .slaveSelectPinN(selWire),
    .portInterruptFlag(flag));
  spm_peer i_peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .asMaster(pMaster), .clock_idle_polarity(pCkp),
    .cke(pCke), .txByte(pTx), .load(pLoad), .go(pGo), .nEdges(pEdges), .halfP(6'h05),
    .sckIn(sckWire), .selInN(tbSelN), .dataIn(sdoWire), .sckOut(pSck), .selOutN(pSelN),
    .dataOut(pData), .rxByte(pRx), .busy(pBusy));
  always #5 sys_clk = ~sys_clk;
  // Timer tick every third cycle; serial clock edges logged by cycle
  always @(posedge sys_clk) begin
    tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
    timerTick <= (tickCnt == 2'h2);
    cyc++;
    sckPrev <= sckOut;
    if (sckOut !== sckPrev) begin
      if (edges == mark)
        firstCyc = cyc;
      edges++;
      lastCyc = cyc;
    end
  end
  task automatic end_sim();
    $display("TB: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    q = prdata;
    e = pslverr;
    guard(n, 16);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, {24'h0, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    `CHK(q, {24'h0, d})
  endtask
  task automatic waitFlag();
    int n;
    n = 0;
    while (flag !== 1'h1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    guard(n, 3000);
    // Let the far side's last capture settle before it is compared
    @(posedge sys_clk);
  endtask
  task automatic cfg(input logic [3:0] md, input logic pol, input logic ph, input logic [7:0] t);
    tbSelN <= 1'h1;
    pCkp <= pol;
    pCke <= ph;
    wr(spm_pkg::OFF_CTRL1, 8'h00);
    wr(spm_pkg::OFF_STAT, {smpBit, ph, 6'h00});
    wr(spm_pkg::OFF_CTRL1, {2'h0, 1'h1, pol, md});
    tbSelN <= 1'h0;
    pTx <= t;
    pLoad <= 1'h1;
    @(posedge sys_clk);
    pLoad <= 1'h0;
    // Idle-level change of the clock is logged before counting starts
    @(posedge sys_clk);
    mark = edges;
  endtask
  task automatic mRun(input logic [7:0] tx, input logic [7:0] prx, input int half);
    wr(spm_pkg::OFF_DATA, tx);
    waitFlag();
    `CHK(pRx, tx)
    `CHK(edges - mark, 16)
    `CHK(lastCyc - firstCyc, 15 * half)
    `CHK(sckOut, pCkp)
    rd(spm_pkg::OFF_STAT, {smpBit, pCke, 6'h01});
    rd(spm_pkg::OFF_DATA, prx);
    rd(spm_pkg::OFF_STAT, {smpBit, pCke, 6'h00});
    `CHK(flag, 1'h1)
    wr(spm_pkg::OFF_FLAG, 8'h01);
    `CHK(flag, 1'h0)
  endtask
  task automatic frame(input logic [4:0] ne, input logic [7:0] t);
    int n;
    n = 0;
    pEdges <= ne;
    pTx <= t;
    pLoad <= 1'h1;
    @(posedge sys_clk);
    pLoad <= 1'h0;
    pGo <= 1'h1;
    @(posedge sys_clk);
    pGo <= 1'h0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pBusy === 1'h1 && n < 500);
    guard(n, 500);
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    rd(spm_pkg::OFF_CTRL1, spm_pkg::CTRL1_RST);
    rd(spm_pkg::OFF_STAT, 8'h00);
    rd(spm_pkg::OFF_BAUD, spm_pkg::BAUD_RST);
    apb(1'h0, 8'h14, 32'h0, q, e);
    `CHK({e, q}, 33'h100000000)
    wr(spm_pkg::OFF_CTRL1, 8'hDF);
    rd(spm_pkg::OFF_CTRL1, 8'hDF);
    wr(spm_pkg::OFF_STAT, 8'hFF);
    rd(spm_pkg::OFF_STAT, 8'hC0);
    wr(spm_pkg::OFF_BAUD, 8'h02);
    rd(spm_pkg::OFF_BAUD, 8'h02);
    $display("TB: registers done");
    for (int i = 0; i < 5; i++) begin
      cfg(mdTab[i], polTab[i], phTab[i], 8'h3C ^ 8'(i));
      mRun(8'hA5 + 8'(i), 8'h3C ^ 8'(i), halfTab[i]);
    end
    smpBit = 1'h1;
    cfg(spm_pkg::MODE_DIV16, 1'h1, 1'h1, 8'h5D);
    mRun(8'hB4, 8'h5D, int'(spm_pkg::HALF_DIV16));
    smpBit = 1'h0;
    $display("TB: master modes done");
    cfg(spm_pkg::MODE_DIV16, 1'h0, 1'h1, 8'h69);
    wr(spm_pkg::OFF_DATA, 8'hC6);
    wr(spm_pkg::OFF_DATA, 8'h17);
    rd(spm_pkg::OFF_CTRL1, {4'hA, spm_pkg::MODE_DIV16});
    waitFlag();
    `CHK(pRx, 8'hC6)
    wr(spm_pkg::OFF_FLAG, 8'h01);
    mark = edges;
    wr(spm_pkg::OFF_DATA, 8'h17);
    repeat (40) @(posedge sys_clk);
    `CHK(edges - mark, 0)
    rd(spm_pkg::OFF_DATA, 8'h69);
    cfg(spm_pkg::MODE_DIV16, 1'h0, 1'h1, 8'h4B);
    mRun(8'h17, 8'h4B, 8);
    $display("TB: collision done");
    pMaster <= 1'h1;
    blockSel <= 1'h1;
    cfg(spm_pkg::MODE_SLV_SEL, 1'h0, 1'h1, 8'h00);
    `CHK({sckOe, sdoOe}, 2'h0)
    wr(spm_pkg::OFF_DATA, 8'h5A);
    rd(spm_pkg::OFF_DATA, 8'h5A);
    frame(5'h10, 8'hC3);
    `CHK({flag, sdoOe}, 2'h0)
    blockSel <= 1'h0;
    frame(5'h10, 8'hC3);
    waitFlag();
    `CHK(pRx, 8'h5A)
    rd(spm_pkg::OFF_DATA, 8'hC3);
    wr(spm_pkg::OFF_FLAG, 8'h01);
    frame(5'h06, 8'hFF);
    `CHK(flag, 1'h0)
    wr(spm_pkg::OFF_DATA, 8'h96);
    frame(5'h10, 8'h3E);
    waitFlag();
    `CHK(pRx, 8'h96)
    rd(spm_pkg::OFF_DATA, 8'h3E);
    wr(spm_pkg::OFF_FLAG, 8'h01);
    $display("TB: slave select done");
    cfg(spm_pkg::MODE_SLV_NOSEL, 1'h1, 1'h0, 8'h00);
    wr(spm_pkg::OFF_DATA, 8'hE1);
    frame(5'h10, 8'h11);
    waitFlag();
    wr(spm_pkg::OFF_FLAG, 8'h01);
    frame(5'h10, 8'h22);
    waitFlag();
    `CHK(pRx, 8'h11)
    rd(spm_pkg::OFF_DATA, 8'h22);
    $display("TB: slave free done");
    end_sim();
  end
endmodule
